// ==== hdl/vaq_pkg.sv ====
// constants and types shared by the voice alert event queue
package vaq_pkg;
  // register offsets
  localparam logic [7:0] REG_TIMEOUT    = 8'h08;  // alert_timeout
  localparam logic [7:0] REG_SWTRIG     = 8'h09;  // software_trigger
  localparam logic [7:0] TIMEOUT_RESET  = 8'h00;  // timer idle after reset
  localparam logic [7:0] SWTRIG_RESET   = 8'h00;  // no software event staged
  // event vector codes
  localparam logic [7:0] VEC_CPU        = 8'h01;  // cpu absent
  localparam logic [7:0] VEC_TRAP_BASE  = 8'h02;  // trap 1, traps 2..5 follow
  localparam logic [7:0] VEC_MON_BASE   = 8'h40;  // voltage 0, rest follow
  localparam logic [7:0] VEC_SW_BASE    = 8'h80;  // software events 80..FF
  localparam logic [7:0] VEC_RSV_0      = 8'h00;  // never queued
  localparam logic [7:0] VEC_RSV_1      = 8'h32;  // never queued
  // source layout of the pending vector, lowest index served first
  localparam int NUM_TRAPS = 5;                    // hardware trap inputs
  localparam int NUM_MON   = 17;                   // monitor events
  localparam int NUM_SRC   = 1 + NUM_TRAPS + 1 + NUM_MON;
  localparam int IDX_SW    = 6;                    // software slot
  localparam int IDX_MON0  = 7;                    // first monitor slot
  // timing
  localparam int CLK_PERIOD_NS    = 8;             // 125 mhz
  localparam int TIMEOUT_UNIT_US  = 1000;          // one timeout count
  localparam int TICK_CYCLES_DEF  = TIMEOUT_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam int FLASH_HALF_NS    = 40;            // least half period of strobes
  localparam int HALF_CYCLES      = (FLASH_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // voice flash
  localparam int FLASH_ADDR_BITS  = 21;            // 16 mbit of byte storage
  localparam int SLOT_SHIFT       = 13;            // bytes per vector slot, log2
  localparam int CTRL_READ_PULSES = 1;             // control pulses for read mode
  localparam int SAMPLES_DEF      = 4096;          // samples per voice
  localparam int QUEUE_DEPTH_DEF  = 8;             // queue entries
  // player states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CTRL = 4'b0010,
    ST_ADDR = 4'b0100,
    ST_READ = 4'b1000
  } vaq_state_t;
endpackage

// ==== hdl/vaq_top.sv ====
// voice alert event queue: event capture, priority, queue and voice player
`timescale 1ns/1ps

module vaq_fifo #(
  parameter int WIDTH = 8,                         // word width
  parameter int DEPTH = 8                          // entries
) (
  input  wire logic             clock_i,           // clock
  input  wire logic             rst_n_i,           // sync reset, low
  input  wire logic             in_valid_i,        // write request
  output logic                  in_ready_o,        // room left
  input  wire logic [WIDTH-1:0] in_data_i,         // write word
  output logic                  out_valid_o,       // word available
  input  wire logic             out_ready_i,       // reader takes word
  output logic      [WIDTH-1:0] out_data_o         // oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];                   // storage
  logic [AW-1:0]    wr_ptr;                        // next write slot
  logic [AW-1:0]    rd_ptr;                        // oldest slot
  logic [AW:0]      count;                         // words held
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  // storage write, no reset needed on data
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers wrap at depth, count tracks fill
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module vaq_top
  import vaq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,     // cycles per timeout count
  parameter int SAMPLES     = SAMPLES_DEF,         // samples per voice
  parameter int QUEUE_DEPTH = QUEUE_DEPTH_DEF      // queue entries
) (
  input  wire logic          clock_i,              // 125 mhz clock
  input  wire logic          rst_n_i,              // sync reset, low
  input  wire logic [7:0]    reg_addr_i,           // register offset
  input  wire logic [7:0]    reg_wdata_i,          // write data
  input  wire logic          reg_wr_i,             // write strobe
  output logic      [7:0]    reg_rdata_o,          // read data, one cycle late
  input  wire logic          voice_gpio_strap_i,   // strap pin
  input  wire logic          cpu_absent_n_i,       // high when cpu absent
  input  wire logic [4:0]    trap_in_i,            // trap pins, input
  output logic      [4:0]    trap_out_o,           // trap pins, output
  output logic      [4:0]    trap_oe_o,            // trap pins, enable
  input  wire logic [4:0]    gpio_out_i,           // general io drive value
  input  wire logic [4:0]    gpio_oe_i,            // general io enable
  output logic      [4:0]    gpio_in_o,            // filtered pin levels
  input  wire logic          pwm_sel_4_i,          // trap 4 pin as pwm
  input  wire logic [7:0]    pwm_duty_4_i,         // software duty
  input  wire logic          tach_sel_4_5_i,       // traps 2-3 pins as tach
  output logic      [1:0]    tach_in_4_5_o,        // tach levels
  input  wire logic [16:0]   mon_event_i,          // monitor violations
  input  wire logic [16:0]   mon_mask_i,           // interrupt masks
  input  wire logic [16:0]   mon_clr_i,            // status clears
  output logic      [16:0]   mon_status_o,         // sticky status
  output logic               sys_mgmt_irq_n_o,     // management irq, low
  output logic               irq_o,                // interrupt request
  output logic               addr_pulse_o,         // flash address pulse
  output logic               voice_clock_out_o,    // flash data clock
  output logic               ctrl_pulse_o,         // flash mode pulses
  output logic               mode_o,               // high during a voice
  input  wire logic          flash_data_i,         // flash data, input
  output logic               flash_data_o,         // flash data, output
  output logic               flash_data_oe_o,      // flash data, enable
  output logic      [7:0]    dac_o,                // current dac code
  output logic      [7:0]    vector_o,             // vector being played
  output logic               queue_full_o          // queue holds all entries
);
  localparam logic [7:0]  HALF_M1 = 8'(HALF_CYCLES - 1);
  localparam logic [31:0] TICK_M1 = 32'(TICK_CYCLES - 1);
  localparam logic [15:0] SAMP_M1 = 16'(SAMPLES - 1);
  localparam logic [4:0]  ABIT_M1 = 5'(FLASH_ADDR_BITS - 1);
  localparam logic [4:0]  CTRL_M1 = 5'(CTRL_READ_PULSES - 1);

  // three stage synchronisers: cpu, traps, flash data, strap
  logic [7:0] s1, s2, s3, clean;
  wire  [7:0] pins = {voice_gpio_strap_i, flash_data_i, trap_in_i, cpu_absent_n_i};
  wire  [7:0] agree = ~(s2 ^ s3);
  wire  [7:0] rise  = s2 & s3 & ~clean;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      clean <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      clean <= (agree & s3) | (~agree & clean);
    end
  end

  // strap_hi loads the third stage during the first three cycles after reset, while that stage still holds its reset zero
  logic [1:0] strap_cnt;
  logic       strap_hi;                            // 1: pins are general io
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      strap_cnt <= '0;
      strap_hi  <= 1'b0;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 2'h1;
      strap_hi  <= s3[7];
    end
  end

  // pin muxing: alternate functions take the pin from the event logic
  wire [4:0] alt_fn   = {1'b0, pwm_sel_4_i, tach_sel_4_5_i, tach_sel_4_5_i, 1'b0};
  wire [4:0] trap_ev  = rise[5:1] & ~alt_fn & {5{~strap_hi}};
  logic [7:0] pwm_cnt;                             // free running pwm ramp
  wire        pwm_bit = (pwm_cnt < pwm_duty_4_i);
  wire [4:0] next_out = strap_hi ? gpio_out_i : {1'b0, pwm_bit, 3'h0};
  wire [4:0] next_oe  = strap_hi ? gpio_oe_i : {1'b0, pwm_sel_4_i, 3'h0};
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pwm_cnt       <= '0;
      trap_out_o    <= '0;
      trap_oe_o     <= '0;
      gpio_in_o     <= '0;
      tach_in_4_5_o <= '0;
    end else begin
      pwm_cnt       <= pwm_cnt + 8'h01;
      trap_out_o    <= next_out;
      trap_oe_o     <= next_oe;
      gpio_in_o     <= clean[5:1];
      tach_in_4_5_o <= tach_sel_4_5_i ? clean[3:2] : 2'h0;
    end
  end

  // monitor violations: sticky status, new event beats clear
  logic [16:0] mon_prev;
  wire  [16:0] mon_rise = mon_event_i & ~mon_prev;
  wire  [16:0] next_status = (mon_status_o & ~mon_clr_i) | mon_event_i;
  wire         irq_any = |(next_status & ~mon_mask_i);
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mon_prev         <= '0;
      mon_status_o     <= '0;
      sys_mgmt_irq_n_o <= 1'b1;
      irq_o            <= 1'b0;
    end else begin
      mon_prev         <= mon_event_i;
      mon_status_o     <= next_status;
      sys_mgmt_irq_n_o <= ~irq_any;
      irq_o            <= irq_any;
    end
  end

  // software trigger and timeout; a rewrite of the timeout restarts it
  logic [7:0]  alert_timeout;                      // counts left
  logic [7:0]  software_trigger;                   // staged event
  logic        sw_armed;                           // event waiting for expiry
  logic        run;                                // timer counting
  logic [31:0] pre;                                // prescaler
  wire wr_to  = reg_wr_i & (reg_addr_i == REG_TIMEOUT);
  wire wr_sw  = reg_wr_i & (reg_addr_i == REG_SWTRIG);
  wire unit   = run & (pre == TICK_M1);
  wire expire = unit & (alert_timeout == 8'h01);
  wire sw_fire = expire & sw_armed & ~wr_sw;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      alert_timeout    <= TIMEOUT_RESET;
      software_trigger <= SWTRIG_RESET;
      sw_armed         <= 1'b0;
      run              <= 1'b0;
      pre              <= '0;
    end else begin
      pre <= (wr_to || unit) ? '0 : pre + 32'h1;
      if (wr_to) begin
        alert_timeout <= reg_wdata_i;              // refresh
        run           <= (reg_wdata_i != 8'h00);
      end else if (unit) begin
        alert_timeout <= alert_timeout - 8'h01;
        run           <= ~expire;
      end
      if (wr_sw) begin
        software_trigger <= reg_wdata_i;
        sw_armed         <= 1'b1;
      end else if (expire) begin
        sw_armed <= 1'b0;
      end
    end
  end

  // readback: remaining timeout counts and staged trigger
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= (reg_addr_i == REG_TIMEOUT) ? alert_timeout :
                     (reg_addr_i == REG_SWTRIG)  ? software_trigger : 8'h00;
    end
  end

  // vector coding per source slot
  function automatic logic [7:0] vec_of(input logic [4:0] idx, input logic [7:0] sw);
    logic [7:0] v;
    v = VEC_MON_BASE + 8'(idx) - 8'(IDX_MON0);
    if (idx == 5'd0) begin
      v = VEC_CPU;
    end else if (idx < 5'(IDX_SW)) begin
      v = VEC_TRAP_BASE + 8'(idx) - 8'h01;
    end else if (idx == 5'(IDX_SW)) begin
      v = VEC_SW_BASE | {1'b0, sw[6:0]};
    end
    return v;
  endfunction

  // lowest pending index wins
  function automatic logic [4:0] first_idx(input logic [NUM_SRC-1:0] p);
    logic [4:0] f;
    f = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        f = 5'(i);
      end
    end
    return f;
  endfunction

  // pending events, pushed one per cycle in priority order
  logic [NUM_SRC-1:0] pend;
  logic               q_in_ready;
  logic               q_out_valid;
  logic [7:0]         q_out_data;
  vaq_state_t         state;
  wire [NUM_SRC-1:0] new_ev = {mon_rise, sw_fire, trap_ev, rise[0]};
  wire [4:0]         sel    = first_idx(pend);
  wire [7:0]         sel_vec = vec_of(sel, software_trigger);
  wire               sel_ok = (sel_vec != VEC_RSV_0) && (sel_vec != VEC_RSV_1);
  wire               q_push = (pend != '0) & q_in_ready & sel_ok;
  wire [NUM_SRC-1:0] grant  = (pend != '0) & q_in_ready ? NUM_SRC'(1) << sel : '0;
  wire [NUM_SRC-1:0] next_pend = (pend & ~grant) | (new_ev & {NUM_SRC{q_in_ready}});
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pend         <= '0;
      queue_full_o <= 1'b0;
    end else begin
      pend         <= next_pend;
      queue_full_o <= ~q_in_ready;
    end
  end

  // queue between event logic and player; player stalls it while busy
  vaq_fifo #(
    .WIDTH (8),
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (q_push),
    .in_ready_o  (q_in_ready),
    .in_data_i   (sel_vec),
    .out_valid_o (q_out_valid),
    .out_ready_i (state == ST_IDLE),
    .out_data_o  (q_out_data)
  );

  // voice player: control pulses, serial address, then sample bytes
  logic [7:0]  div;                                // half period divider
  logic        hi;                                 // strobe phase
  logic [4:0]  bit_cnt;                            // pulses or bits sent
  logic [20:0] addr_sh;                            // address shifter
  logic [7:0]  in_byte;                            // sample being gathered
  logic [15:0] samp;                               // samples played
  wire tick = (state != ST_IDLE) & (div == HALF_M1);
  wire fall = tick & hi;                           // strobes drop here
  wire [7:0] byte_in = {in_byte[6:0], s3[6]};
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      div <= '0;
      hi <= 1'b0;
      bit_cnt <= '0;
      addr_sh <= '0;
      in_byte <= '0;
      samp <= '0;
      vector_o <= '0;
      dac_o <= '0;
      mode_o <= 1'b0;
      flash_data_o <= 1'b0;
      flash_data_oe_o <= 1'b0;
      addr_pulse_o <= 1'b0;
      voice_clock_out_o <= 1'b0;
      ctrl_pulse_o <= 1'b0;
    end else begin
      div <= tick ? '0 : div + 8'h01;
      if (tick) begin
        hi <= ~hi;
        ctrl_pulse_o <= ~hi & (state == ST_CTRL);
        addr_pulse_o <= ~hi & (state == ST_ADDR);
        voice_clock_out_o <= ~hi & (state == ST_READ);
      end
      case (state)
        ST_IDLE: begin
          div <= '0;
          hi <= 1'b0;
          bit_cnt <= '0;
          samp <= '0;
          if (q_out_valid) begin
            vector_o <= q_out_data;
            addr_sh <= {q_out_data, 13'h0000};
            mode_o <= 1'b1;
            state <= ST_CTRL;
          end
        end
        ST_CTRL: begin
          if (fall) begin
            bit_cnt <= (bit_cnt == CTRL_M1) ? '0 : bit_cnt + 5'h01;
            if (bit_cnt == CTRL_M1) begin
              flash_data_o <= addr_sh[20];
              flash_data_oe_o <= 1'b1;
              state <= ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          if (fall) begin
            addr_sh <= {addr_sh[19:0], 1'b0};
            flash_data_o <= addr_sh[19];
            bit_cnt <= (bit_cnt == ABIT_M1) ? '0 : bit_cnt + 5'h01;
            if (bit_cnt == ABIT_M1) begin
              flash_data_oe_o <= 1'b0;
              flash_data_o <= 1'b0;
              state <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (fall) begin
            in_byte <= byte_in;
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt[2:0] == 3'h7) begin
              dac_o <= byte_in;
              samp <= samp + 16'h0001;
              if (samp == SAMP_M1) begin
                mode_o <= 1'b0;
                state <= ST_IDLE;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== verif/vaq_flash_model.sv ====
// serial voice flash model: address in, sample bytes out
`timescale 1ns/1ps
module vaq_flash_model (
  input  wire logic       clock_i,              // clock
  input  wire logic       rst_n_i,              // sync reset, low
  input  wire logic       mode_i,               // voice in progress
  input  wire logic       addr_pulse_i,         // address strobe
  input  wire logic       voice_clock_i,        // data strobe
  input  wire logic       data_i,               // wire level
  output logic            data_o,               // bit offered to the wire
  output logic      [7:0] vec_o                 // vector part of taken address
);
  logic [20:0] addr;                            // address shift register
  logic [4:0]  n_a;                             // address bits taken
  logic [15:0] n_b;                             // data bits sent
  logic        ap_q;                            // strobe delayed
  logic        vc_q;                            // strobe delayed
  logic        d_q;                             // wire level of the earlier edge
  logic [7:0]  pat;                             // vector xor byte index
  assign pat   = addr[20:13] ^ n_b[10:3];
  assign vec_o = addr[20:13];
  // falls seen one edge late; shift the earlier wire copy
  always_ff @(posedge clock_i) begin
    ap_q <= addr_pulse_i;
    vc_q <= voice_clock_i;
    d_q  <= data_i;
    if (!rst_n_i || !mode_i) begin
      n_a    <= 5'h00;
      n_b    <= 16'h0000;
      data_o <= rst_n_i ? !data_o : 1'b0;       // idle wire toggles, held low in reset
    end else if (n_a != 5'h15) begin
      data_o <= !data_o;                        // design drives
      if (ap_q && !addr_pulse_i) begin
        addr <= {addr[19:0], d_q};
        n_a  <= n_a + 5'h01;
      end
    end else begin
      data_o <= pat[3'h7 - n_b[2:0]];           // msb first
      if (vc_q && !voice_clock_i) begin
        n_b <= n_b + 16'h0001;
      end
    end
  end
endmodule

// ==== verif/vaq_monitor.sv ====
// assertion checker for the voice alert event queue
`timescale 1ns/1ps
module vaq_monitor
  import vaq_pkg::*;
#(
  parameter int SAMPLES = 2                     // samples per voice
) (
  input  wire logic        clock_i,             // clock
  input  wire logic        rst_n_i,             // sync reset, low
  input  wire logic [7:0]  reg_addr_i,          // offset
  input  wire logic [7:0]  reg_wdata_i,         // write data
  input  wire logic        reg_wr_i,            // write strobe
  input  wire logic [7:0]  reg_rdata_o,         // read data
  input  wire logic [16:0] mon_event_i,         // violations
  input  wire logic [16:0] mon_mask_i,          // masks
  input  wire logic [16:0] mon_clr_i,           // clears
  input  wire logic [16:0] mon_status_o,        // sticky status
  input  wire logic        irq_o,               // interrupt
  input  wire logic        addr_pulse_o,        // address strobe
  input  wire logic        voice_clock_out_o,   // data strobe
  input  wire logic        ctrl_pulse_o,        // mode strobe
  input  wire logic        mode_o,              // voice active
  input  wire logic [7:0]  dac_o,               // sample code
  input  wire logic [7:0]  vector_o,            // vector played
  input  wire logic        queue_full_o         // queue full
);
  logic [4:0]  n_addr;                          // address strobes this voice
  logic [15:0] n_vclk;                          // data strobes this voice
  logic        ap_q;                            // strobe delayed
  logic        vc_q;                            // strobe delayed
  // count strobe rises per voice
  always_ff @(posedge clock_i) begin
    ap_q <= addr_pulse_o;
    vc_q <= voice_clock_out_o;
    if (!mode_o) begin
      n_addr <= 5'h00;
      n_vclk <= 16'h0000;
    end else begin
      n_addr <= n_addr + 5'(addr_pulse_o && !ap_q);
      n_vclk <= n_vclk + 16'(voice_clock_out_o && !vc_q);
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_RSV_VEC: assert property ($rose(mode_o) |-> vector_o != VEC_RSV_0 && vector_o != VEC_RSV_1)
    else $error("reserved vector played");
  AST_VEC_HOLD: assert property (mode_o [*2] |-> $stable(vector_o))
    else $error("vector moved");
  AST_CTRL_FIRST: assert property ($rose(mode_o) |-> ##[0:12] ctrl_pulse_o)
    else $error("no mode strobe");
  AST_ADDR_BITS: assert property ($fell(mode_o) |-> n_addr == 5'h15)
    else $error("address strobe count wrong");
  AST_VCLK_BITS: assert property ($fell(mode_o) |-> n_vclk == 16'(8 * SAMPLES))
    else $error("data strobe count wrong");
  AST_DAC_IDLE: assert property (!mode_o [*2] |-> $stable(dac_o))
    else $error("dac moved while idle");
  AST_FULL_BUSY: assert property ($rose(queue_full_o) |-> mode_o)
    else $error("full while idle");
  AST_STATUS: assert property (mon_event_i != 17'h0 && mon_clr_i == 17'h0
    |-> ##[1:2] mon_status_o != 17'h0)
    else $error("status not set");
  AST_IRQ_ON: assert property (((mon_status_o & ~mon_mask_i) != 17'h0) [*2] |-> ##[0:2] irq_o)
    else $error("irq missing");
  AST_IRQ_OFF: assert property (((mon_status_o & ~mon_mask_i) == 17'h0) [*3] |-> !irq_o)
    else $error("stray irq");
  AST_RD_NONE: assert property (reg_addr_i != REG_TIMEOUT && reg_addr_i != REG_SWTRIG
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_TRIG: assert property (reg_wr_i && reg_addr_i == REG_SWTRIG ##1
    !reg_wr_i && reg_addr_i == REG_SWTRIG |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("trigger readback wrong");
  cover property ($rose(mode_o));
  cover property ($rose(queue_full_o));
  cover property ($rose(irq_o));
endmodule

bind vaq_top vaq_monitor #(.SAMPLES(SAMPLES)) mon_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .mon_event_i(mon_event_i),
  .mon_mask_i(mon_mask_i), .mon_clr_i(mon_clr_i), .mon_status_o(mon_status_o),
  .irq_o(irq_o), .addr_pulse_o(addr_pulse_o), .voice_clock_out_o(voice_clock_out_o),
  .ctrl_pulse_o(ctrl_pulse_o), .mode_o(mode_o), .dac_o(dac_o), .vector_o(vector_o),
  .queue_full_o(queue_full_o));

// ==== verif/vaq_top_bench.sv ====
// self-checking bench for the voice alert event queue
`timescale 1ns/1ps
module vaq_top_bench
  import vaq_pkg::*;
();
  localparam int TICK = 4;                      // short timeout count
  localparam int SMP  = 2;                      // short voices
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic [22:0] src = 23'h0;                     // sources by priority
  logic [16:0] mon_mask_i = 17'h0;
  logic [16:0] mon_clr_i = 17'h0;
  logic [7:0]  pwm_duty = 8'h00;
  logic [7:0]  reg_rdata_o, dac_o, vector_o, mvec, cur;
  logic [16:0] mon_status_o;
  logic        irq_o, sys_mgmt_irq_n_o, mode_o, queue_full_o;
  logic        ap, vc, cp, fd_o, fd_oe, md;
  wire         fd = fd_oe ? fd_o : md;          // address out, data in
  logic [7:0]  exp_q[$];                        // expected vectors
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;

  vaq_top #(.TICK_CYCLES(TICK), .SAMPLES(SMP)) uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .voice_gpio_strap_i(1'b0),
    .cpu_absent_n_i(src[0]), .trap_in_i(src[5:1]), .trap_out_o(), .trap_oe_o(),
    .gpio_out_i(pwm_duty[4:0]), .gpio_oe_i(5'h00), .gpio_in_o(), .pwm_sel_4_i(1'b0),
    .pwm_duty_4_i(pwm_duty), .tach_sel_4_5_i(1'b0), .tach_in_4_5_o(),
    .mon_event_i(src[22:6]), .mon_mask_i(mon_mask_i), .mon_clr_i(mon_clr_i),
    .mon_status_o(mon_status_o), .sys_mgmt_irq_n_o(sys_mgmt_irq_n_o), .irq_o(irq_o),
    .addr_pulse_o(ap), .voice_clock_out_o(vc), .ctrl_pulse_o(cp), .mode_o(mode_o),
    .flash_data_i(fd), .flash_data_o(fd_o), .flash_data_oe_o(fd_oe), .dac_o(dac_o),
    .vector_o(vector_o), .queue_full_o(queue_full_o));
  vaq_flash_model flash (.clock_i(clock_i), .rst_n_i(rst_n_i), .mode_i(mode_o),
    .addr_pulse_i(ap), .voice_clock_i(vc), .data_i(fd), .data_o(md), .vec_o(mvec));

  always #4 clock_i = ~clock_i;
  // hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [16:0] e, input logic [16:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [7:0] vec_of(input int i);
    if (i == 0) return VEC_CPU;
    if (i < 6) return VEC_TRAP_BASE + 8'(i - 1);
    return VEC_MON_BASE + 8'(i - 6);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    @(posedge clock_i);
    #1 chk("reg_rdata_o", e, reg_rdata_o);
  endtask
  // wait for every noted voice to play
  task automatic drain();
    int n = 0;
    while ((exp_q.size() != 0 || mode_o !== 1'b0) && n < 9000) begin
      @(posedge clock_i);
      n++;
    end
    if (n == 9000) begin
      n_fail++;
      wrap_up();
    end
    repeat (4) @(posedge clock_i);
  endtask
  // each voice start takes the oldest note
  always @(posedge mode_o) begin
    #1;
    if (exp_q.size() == 0) begin
      n_fail++;
      $display("wrong value vector_o expected none seen %h", vector_o);
    end else begin
      cur = exp_q.pop_front();
      chk("vector_o", cur, vector_o);
    end
  end
  always @(negedge mode_o) begin
    #1;
    if (rst_n_i === 1'b1) begin
      chk("flash address vector", cur, mvec);
      chk("dac_o", cur ^ 8'(SMP - 1), dac_o);
    end
  end

  initial begin
    void'($urandom(12));
    pwm_duty <= 8'($urandom);
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    #1 chk("sys_mgmt_irq_n_o", 1'b1, sys_mgmt_irq_n_o);
    chk("queue_full_o", 1'b0, queue_full_o);
    rd(REG_TIMEOUT, TIMEOUT_RESET);
    rd(REG_SWTRIG, SWTRIG_RESET);
    wr(8'h0A, 8'h5A);
    rd(8'h0A, 8'h00);
    // every source alone, rising then falling
    for (int i = 0; i < 23; i++) begin
      exp_q.push_back(vec_of(i));
      @(posedge clock_i);
      src[i] <= 1'b1;
      repeat (8) @(posedge clock_i);
      src[i] <= 1'b0;
      drain();
    end
    // flood: all sixteen pended play; later ones arrive full and drop
    for (int i = 0; i < 16; i++) exp_q.push_back(vec_of(i));
    @(posedge clock_i);
    src[5:0] <= 6'h3F;
    repeat (4) @(posedge clock_i);
    src[15:6] <= 10'h3FF;
    repeat (14) @(posedge clock_i);
    #1 chk("queue_full_o", 1'b1, queue_full_o);
    @(posedge clock_i);
    src[22:16] <= 7'h7F;
    repeat (2) @(posedge clock_i);
    src <= 23'h0;
    drain();
    // status clear, mask, then unmask
    mon_clr_i <= 17'h1FFFF;
    repeat (2) @(posedge clock_i);
    mon_clr_i  <= 17'h0;
    mon_mask_i <= 17'h1FFFF;
    repeat (4) @(posedge clock_i);
    #1 chk("mon_status_o", 17'h0, mon_status_o);
    chk("irq_o", 1'b0, irq_o);
    exp_q.push_back(vec_of(22));
    @(posedge clock_i);
    src[22] <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1 chk("mon_status_o", 17'h10000, mon_status_o);
    chk("irq_o masked", 1'b0, irq_o);
    @(posedge clock_i);
    mon_mask_i <= 17'h0;
    src[22]    <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1 chk("irq_o", 1'b1, irq_o);
    chk("sys_mgmt_irq_n_o", 1'b0, sys_mgmt_irq_n_o);
    drain();
    // refreshed then stopped timer: no voice
    wr(REG_TIMEOUT, 8'h03);
    wr(REG_SWTRIG, 8'h11);
    rd(REG_SWTRIG, 8'h11);
    repeat (5) wr(REG_TIMEOUT, 8'h03);
    wr(REG_TIMEOUT, 8'h00);
    repeat (40) @(posedge clock_i);
    // expiry plays staged code
    for (int i = 0; i < 5; i++) begin
      logic [7:0] t;
      t = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
      exp_q.push_back(VEC_SW_BASE | {1'b0, t[6:0]});
      wr(REG_TIMEOUT, 8'h02);
      wr(REG_SWTRIG, t);
      drain();
    end
    wrap_up();
  end
endmodule
